/* File: common/cmd_link_if.sv */
interface cmd_link_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [2:0] bank;
    logic [15:0] addr;
    logic [7:0] dq_wr;
    logic wr_valid;
    logic [7:0] dq_rd;
    logic dq_oe;
    modport memory (input cs_n, ras_n, cas_n, we_n, cke, bank, addr,
        dq_wr, wr_valid, output dq_rd, dq_oe);
    modport controller (output cs_n, ras_n, cas_n, we_n, cke, bank, addr,
        dq_wr, wr_valid, input dq_rd, dq_oe);
endinterface

/* File: common/mode_burst_pkg.sv */
package mode_burst_pkg;
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_PRE = 4'h2;
    // mode_register_zero field positions
    localparam int BL_LSB = 0;
    localparam int BT_POS = 3;
    localparam int WR_LSB = 9;
    localparam int OTF_POS = 12;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    // timing, 250 MHz clock
    localparam int CLK_PS = 4000;
    localparam int MODE_SET_CYCLE_TIME_NS = 4;
    localparam int SETTING_APPLY_DELAY_NS = 12;
    localparam int WRITE_RECOVERY_NS = 15;
    localparam int PRECHARGE_PERIOD_NS = 14;
    localparam int MRD_CYC = (MODE_SET_CYCLE_TIME_NS * 1000 + CLK_PS - 1)
        / CLK_PS;
    localparam int MOD_CYC = (SETTING_APPLY_DELAY_NS * 1000 + CLK_PS - 1)
        / CLK_PS;
    localparam int WR_MIN_CYC = (WRITE_RECOVERY_NS * 1000 + CLK_PS - 1)
        / CLK_PS;
    localparam int RP_CYC = (PRECHARGE_PERIOD_NS * 1000 + CLK_PS - 1)
        / CLK_PS;
    localparam int BEATS = 8;

    // column of beat k for start column and burst type
    function automatic logic [2:0] beat_col(input logic [2:0] start,
            input logic [2:0] k, input logic interleave);
        logic [1:0] low;
        low = interleave ? (start[1:0] ^ k[1:0])
            : 2'(start[1:0] + k[1:0]);
        return {start[2] ^ k[2], low};
    endfunction

    // programmed write recovery field to cycles
    function automatic logic [4:0] wr_cycles(input logic [2:0] code);
        logic [4:0] c;
        c = 5'h10;
        unique case (code)
            3'h1: c = 5'h05;
            3'h2: c = 5'h06;
            3'h3: c = 5'h07;
            3'h4: c = 5'h08;
            3'h5: c = 5'h0a;
            3'h6: c = 5'h0c;
            3'h7: c = 5'h0e;
            default: c = 5'h10;
        endcase
        return c;
    endfunction

    function automatic logic [2:0] wr_code(input logic [4:0] cyc);
        logic [2:0] c;
        c = 3'h0;
        if (cyc <= 5'h05) c = 3'h1;
        else if (cyc <= 5'h06) c = 3'h2;
        else if (cyc <= 5'h07) c = 3'h3;
        else if (cyc <= 5'h08) c = 3'h4;
        else if (cyc <= 5'h0a) c = 3'h5;
        else if (cyc <= 5'h0c) c = 3'h6;
        else if (cyc <= 5'h0e) c = 3'h7;
        return c;
    endfunction
endpackage

/* File: core/beat_sequencer.sv */
module beat_sequencer
    import mode_burst_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [2:0] col_i,
    input wire logic interleave_i,
    input wire logic chop_i,
    input wire logic is_write_i,
    output logic active_o,
    output logic [2:0] col_o,
    output logic slot_live_o
);
    logic [3:0] idx_reg;
    logic [2:0] start_reg;
    logic il_reg;
    logic chop_reg;
    logic wr_reg;
    wire running = idx_reg != 4'h8;
    wire [2:0] k = idx_reg[2:0];
    // writes land in plain column order, reads in burst order
    wire [2:0] rd_col = beat_col(start_reg, k, il_reg);
    wire [2:0] wr_col = chop_reg ? {start_reg[2], k[1:0]} : k;
    assign active_o = running;
    assign col_o = wr_reg ? wr_col : rd_col;
    assign slot_live_o = running && !(chop_reg && k[2]);

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            idx_reg <= 4'h8;
            start_reg <= 3'h0;
            il_reg <= 1'b0;
            chop_reg <= 1'b0;
            wr_reg <= 1'b0;
        end else if (ce_i) begin
            if (start_i) begin
                idx_reg <= 4'h0;
                start_reg <= col_i;
                il_reg <= interleave_i;
                chop_reg <= chop_i;
                wr_reg <= is_write_i;
            end else if (running) begin
                idx_reg <= idx_reg + 4'h1;
            end
        end
    end
endmodule

/* File: core/sdram_mode_controller.sv */
module sdram_mode_controller
    import mode_burst_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    cmd_link_if.controller link,
    input wire logic [1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o
);
    // regs: 0 command {op[17:16],sel[14:13]...}, 1 status, 2 write data
    localparam logic [1:0] REG_CMD = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_WDATA = 2'h2;
    localparam logic [1:0] REG_RDATA = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_BURST = 3'b100
    } state_t;
    state_t state_reg;
    logic [3:0] wait_reg;
    logic [3:0] beat_reg;
    logic [3:0] cmd_reg;
    logic [2:0] bank_reg;
    logic [15:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic wr_burst_reg;
    logic [31:0] rdata_q;
    wire go = wr_i && addr_i == REG_CMD && state_reg == ST_IDLE;
    wire [1:0] op = wdata_i[17:16];
    // mode set for register zero forces reserved bits and recovery floor
    wire [15:0] mr_addr = wdata_i[14:13] == 2'h0
        ? {3'h0, wdata_i[12], wr_code(5'(WR_MIN_CYC)), wdata_i[8:0]}
        : wdata_i[15:0]; // RULE10 RULE11
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            wait_reg <= 4'h0;
            beat_reg <= 4'h0;
            cmd_reg <= CMD_NOP;
            bank_reg <= 3'h0;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
            wr_burst_reg <= 1'b0;
            rdata_q <= 32'h0;
        end else if (ce_i) begin
            cmd_reg <= CMD_NOP;
            if (wr_i && addr_i == REG_WDATA) wdata_reg <= wdata_i[7:0];
            if (link.dq_oe) rdata_reg <= link.dq_rd;
            // read data stands only in the cycle after the strobe
            rdata_q <= !rd_i ? 32'h0
                : addr_i == REG_STATUS ? {31'h0, state_reg != ST_IDLE}
                : addr_i == REG_RDATA ? {24'h0, rdata_reg} : 32'h0;
            unique case (state_reg)
                ST_IDLE: if (go) begin
                    // one command at a time keeps banks idle for mode set
                    bank_reg <= {1'b0, wdata_i[14:13]}; // RULE8 RULE9
                    addr_reg <= op == 2'h0 ? mr_addr : wdata_i[15:0];
                    cmd_reg <= op == 2'h0 ? CMD_MRS
                        : op == 2'h1 ? CMD_READ : CMD_WRITE; // RULE1
                    wr_burst_reg <= op == 2'h2;
                    wait_reg <= 4'(MOD_CYC > MRD_CYC ? MOD_CYC : MRD_CYC);
                    beat_reg <= 4'h0;
                    state_reg <= op == 2'h0 ? ST_WAIT : ST_BURST;
                end
                ST_WAIT: begin
                    wait_reg <= wait_reg - 4'h1;
                    if (wait_reg == 4'h1) state_reg <= ST_IDLE; // RULE6 RULE7
                end
                ST_BURST: begin
                    beat_reg <= beat_reg + 4'h1;
                    if (beat_reg == 4'(BEATS + 1)) state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    assign link.cs_n = cmd_reg[3];
    assign link.ras_n = cmd_reg[2];
    assign link.cas_n = cmd_reg[1];
    assign link.we_n = cmd_reg[0];
    assign link.cke = 1'b1; // RULE8
    assign link.bank = bank_reg;
    assign link.addr = addr_reg;
    assign link.dq_wr = wdata_reg;
    assign link.wr_valid = state_reg == ST_BURST && wr_burst_reg
        && beat_reg != 4'h0 && beat_reg <= 4'(BEATS);
    assign rdata_o = rdata_q;
endmodule

/* File: core/sdram_mode_device.sv */
// Behaviour
// (RULE1) four mode registers, written only by mode set
// (RULE2) controller must program all registers after reset
// (RULE3) repeated mode set replaces register contents
// (RULE4) controller drives every field on mode set
// (RULE5) mode set never touches array data
// (RULE6) mode set commands spaced by cycle time
// (RULE7) new settings apply within apply delay
// (RULE8) mode set only when idle, clock enable high
// (RULE9) register zero addressed by all-low bank pins
// (RULE10) reserved bits of register zero are zero
// (RULE11) recovery value at least rounded-up write recovery
// (RULE12) recovery plus precharge gives auto-precharge delay
// (RULE13) sequential wraps nibble, interleaved xors index
// (RULE14) address bit 3 picks burst type
// (RULE15) address bits 0-1 pick burst length
// (RULE16) on-the-fly mode samples address bit 12
// (RULE17) order from length, type, start column
// (RULE18) eight-beat reads start at column, ordered
// (RULE19) chopped reads: nibble by bit 2, tristate tail
// (RULE20) writes in column order, chopped tail ignored
//
// Decided for this implementation: the placing of the registers and strobed register access.
module sdram_mode_device
    import mode_burst_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    cmd_link_if.memory link,
    output logic [15:0] mode_zero_o,
    output logic [15:0] mode_one_o,
    output logic [15:0] mode_two_o,
    output logic [15:0] mode_three_o,
    output logic [5:0] autoprecharge_write_delay_o,
    output logic settings_pending_o,
    output logic reserved_error_o
);
    ////////////////////////////////////////////////////////////////////
    logic [15:0] mode_reg [4];
    logic [15:0] staged_reg;
    logic [1:0] staged_sel_reg;
    logic [3:0] apply_cnt_reg;
    logic [7:0] mem [8];
    logic [7:0] dq_rd_reg;
    logic dq_oe_reg;
    logic [5:0] dal_reg;
    logic res_err_reg;

    wire [3:0] cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    wire cmd_ok = link.cke;
    wire is_mrs = cmd_ok && cmd == CMD_MRS;
    wire is_rd = cmd_ok && cmd == CMD_READ;
    wire is_wr = cmd_ok && cmd == CMD_WRITE;
    wire [1:0] mr_sel = link.bank[1:0]; // RULE9
    // reserved bits: bank 2 and address 15:13
    wire res_bad = is_mrs && mr_sel == 2'h0
        && (link.bank[2] || link.addr[15:13] != 3'h0); // RULE10
    // settings in force until the apply delay ends; old values govern
    wire [15:0] mr0 = mode_reg[0];
    wire [1:0] bl_mode = mr0[BL_LSB +: 2]; // RULE15
    wire interleave = mr0[BT_POS]; // RULE14
    wire chop = bl_mode == BL_FIXED4
        || (bl_mode == BL_OTF && !link.addr[OTF_POS]); // RULE16
    wire [2:0] wr_code_f = mr0[WR_LSB +: 3];

    logic seq_active;
    logic [2:0] seq_col;
    logic seq_live;
    ////////////////////////////////////////////////////////////////////
    beat_sequencer beat_sequencer_i (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .start_i(is_rd || is_wr),
        .col_i(link.addr[2:0]), // RULE17
        .interleave_i(interleave), // RULE13
        .chop_i(chop),
        .is_write_i(is_wr),
        .active_o(seq_active),
        .col_o(seq_col),
        .slot_live_o(seq_live)
    );

    logic writing_reg;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            writing_reg <= 1'b0;
        end else if (ce_i && (is_rd || is_wr)) begin
            writing_reg <= is_wr;
        end
    end

    // array only written by write bursts, never by mode set
    always_ff @(posedge core_clk_i) begin
        if (ce_i && seq_active && writing_reg && seq_live
                && link.wr_valid) begin
            mem[seq_col] <= link.dq_wr; // RULE20 RULE5
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dq_rd_reg <= 8'h00;
            dq_oe_reg <= 1'b0;
        end else if (ce_i) begin
            dq_oe_reg <= seq_active && !writing_reg && seq_live; // RULE19
            dq_rd_reg <= mem[seq_col]; // RULE18
        end
    end
    assign link.dq_rd = dq_rd_reg;
    assign link.dq_oe = dq_oe_reg;

    ////////////////////////////////////////////////////////////////////
    // mode set is staged then committed after the apply delay
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            staged_reg <= MODE_RESET;
            staged_sel_reg <= 2'h0;
            apply_cnt_reg <= 4'h0;
            res_err_reg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                mode_reg[i] <= MODE_RESET; // RULE2
            end
        end else if (ce_i) begin
            if (is_mrs) begin
                staged_reg <= link.addr; // RULE4
                staged_sel_reg <= mr_sel;
                apply_cnt_reg <= 4'(MOD_CYC); // RULE7
                res_err_reg <= res_bad;
            end else if (apply_cnt_reg != 4'h0) begin
                apply_cnt_reg <= apply_cnt_reg - 4'h1;
                if (apply_cnt_reg == 4'h1) begin
                    mode_reg[staged_sel_reg] <= staged_reg; // RULE1 RULE3
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dal_reg <= 6'h00;
        end else if (ce_i) begin
            dal_reg <= 6'(wr_cycles(wr_code_f)) + 6'(RP_CYC); // RULE12
        end
    end

    assign mode_zero_o = mode_reg[0];
    assign mode_one_o = mode_reg[1];
    assign mode_two_o = mode_reg[2];
    assign mode_three_o = mode_reg[3];
    assign autoprecharge_write_delay_o = dal_reg;
    assign settings_pending_o = apply_cnt_reg != 4'h0;
    assign reserved_error_o = res_err_reg;
endmodule

/* File: verif/mode_link_monitor.sv */
module mode_link_monitor
    import mode_burst_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [2:0] bank,
    input wire logic [15:0] addr,
    input wire logic [7:0] dq_wr,
    input wire logic wr_valid,
    input wire logic [7:0] dq_rd,
    input wire logic dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [3:0] cmd;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////
    a_cke_high: assert property (cke)
        else $error("clock enable seen low");
    a_mrs_spacing: assert property (cmd == CMD_MRS |=>
        cmd == CMD_NOP [*2]) else $error("mode set too close");
    a_burst_idle: assert property (cmd == CMD_READ |=>
        cmd == CMD_NOP [*8]) else $error("command during burst");
    a_reserved_zero: assert property (cmd == CMD_MRS && bank == 3'h0
        |-> addr[15:13] == 3'h0) else $error("reserved bits set");
    a_bank_two_low: assert property (cmd == CMD_MRS |-> !bank[2])
        else $error("bank bit two high on mode set");
    a_recovery_code: assert property (cmd == CMD_MRS && bank == 3'h0
        |-> addr[11:9] == 3'h1) else $error("recovery code wrong");
    a_addr_held: assert property (cmd == CMD_NOP
        |-> $stable(addr) && $stable(bank)) else $error("address moved");
    a_read_live: assert property (cmd == CMD_READ |->
        ##2 dq_oe [*4]) else $error("read slots not live");
    a_oe_cause: assert property ($rose(dq_oe)
        |-> $past(cmd, 2) == CMD_READ) else $error("drive without read");
    a_write_beats: assert property (cmd == CMD_WRITE |=>
        wr_valid [*4]) else $error("write beats missing");
endmodule

/* File: verif/sdram_mode_register_burst_order_tb.sv */
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    mismatches++; $display("ERROR %0t: got %h want %h", $time, a, b); \
    end end
module sdram_mode_register_burst_order_tb
    import mode_burst_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, sys_rst_i, ce_i, wr_i, rd_i;
    logic [1:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [15:0] m0, m1, m2, m3;
    logic [5:0] apd;
    logic pending, res_err;
    int mismatches = 0;
    int comparisons = 0;
    logic [7:0] beats[$];
    cmd_link_if link();
    sdram_mode_device sdram_mode_device_i (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .link(link.memory),
        .mode_zero_o(m0), .mode_one_o(m1), .mode_two_o(m2),
        .mode_three_o(m3), .autoprecharge_write_delay_o(apd),
        .settings_pending_o(pending), .reserved_error_o(res_err));
    sdram_mode_controller sdram_mode_controller_i (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .link(link.controller),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o));
    mode_link_monitor mode_link_monitor_i (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke),
        .bank(link.bank), .addr(link.addr), .dq_wr(link.dq_wr),
        .wr_valid(link.wr_valid), .dq_rd(link.dq_rd), .dq_oe(link.dq_oe));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    // registered outputs, so the pre-edge value is the live slot
    always @(posedge core_clk_i) begin
        if (link.dq_oe === 1'b1) beats.push_back(link.dq_rd);
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic bus_wr(input logic [1:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic bus_rd(input logic [1:0] a, output logic [31:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge core_clk_i);
    endtask
    // busy covers apply delay and burst length
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        for (n = 0; n < 40; n++) begin
            bus_rd(2'h1, s);
            if (s[0] === 1'b0) break;
        end
        `CHECK(s[0], 1'b0)
        #1;
    endtask
    // a command written while busy is dropped, so always wait
    task automatic cmd(input logic [1:0] op, input logic [15:0] a);
        bus_wr(2'h0, {14'h0, op, a});
        wait_idle();
    endtask
    task automatic rd_burst(input logic [15:0] a, input logic [63:0] e,
            input int n);
        int k;
        beats.delete();
        cmd(2'h1, a);
        `CHECK(beats.size(), n)
        for (k = 0; k < n && k < beats.size(); k++) begin
            `CHECK(beats[k], e[63 - 8 * k -: 8])
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_mode();
        `CHECK(m0, 16'h0000)
        bus_wr(2'h0, 32'h0000_0008);
        #1;
        `CHECK(pending, 1'b1)
        `CHECK(m0, 16'h0000)
        wait_idle();
        `CHECK(m0, 16'h0208)
        cmd(2'h0, 16'h0000);
        `CHECK(m0, 16'h0200)
        cmd(2'h0, 16'h0008);
        `CHECK(m0, 16'h0208)
        `CHECK(pending, 1'b0)
        `CHECK(apd, 6'h09)
        `CHECK(res_err, 1'b0)
        cmd(2'h0, 16'h2044);
        `CHECK(m1[12:0], 13'h0044)
        `CHECK(m0, 16'h0208)
        cmd(2'h0, 16'h4011);
        `CHECK(m2, 16'h4011)
        // frozen block must not take the command
        ce_i <= 1'b0;
        bus_wr(2'h0, 32'h0000_6022);
        #1;
        `CHECK(pending, 1'b0)
        ce_i <= 1'b1;
        cmd(2'h0, 16'h6022);
        `CHECK(m3, 16'h6022)
        `CHECK(m2, 16'h4011)
        $display("test mode done");
    endtask
    // nibble one 0xa5, nibble zero 0x5a, then 0x3c
    task automatic t_burst();
        logic [31:0] r;
        cmd(2'h0, 16'h0000);
        bus_wr(2'h2, 32'h5a);
        cmd(2'h2, 16'h0003);
        cmd(2'h0, 16'h0002);
        bus_wr(2'h2, 32'ha5);
        cmd(2'h2, 16'h0006);
        rd_burst(16'h0001, 64'h5a5a5a5a_00000000, 4);
        rd_burst(16'h0005, 64'ha5a5a5a5_00000000, 4);
        cmd(2'h0, 16'h0000);
        rd_burst(16'h0005, 64'ha5a5a5a5_5a5a5a5a, 8);
        cmd(2'h0, 16'h0009);
        rd_burst(16'h1001, 64'h5a5a5a5a_a5a5a5a5, 8);
        rd_burst(16'h0004, 64'ha5a5a5a5_00000000, 4);
        bus_wr(2'h2, 32'h3c);
        cmd(2'h2, 16'h0000);
        rd_burst(16'h100c, 64'ha5a5a5a5_3c3c3c3c, 8);
        bus_rd(2'h3, r);
        `CHECK(r, 32'h0000_003c)
        $display("test burst done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk_i);
        mismatches++;
        give_verdict();
    end
    initial begin
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 2'h0;
        wdata_i = 32'h0;
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        t_mode();
        t_burst();
        give_verdict();
    end
endmodule
